// >>> swpp_defs.vh
// Purpose: constants for the window-setup parameter parser
// Assumes: byte-serial parameter stream, AXI4-Lite register window
// Notes: offsets are byte addresses of 32-bit registers
`ifndef SWPP_DEFS_VH
`define SWPP_DEFS_VH
// Stream layout
`define SWPP_HDR_LEN 8'h08
`define SWPP_DESC_LEN 16'h002A
`define SWPP_TOTAL 8'h32
// Resolution limits and default
`define SWPP_RES_MIN 16'h0048
`define SWPP_RES_MAX 16'h012C
`define SWPP_RES_DEF 16'h0048
// Register offsets
`define SWPP_REG_CTRL 8'h00
`define SWPP_REG_STATUS 8'h04
`define SWPP_REG_XRES 8'h08
`define SWPP_REG_YRES 8'h0C
`define SWPP_REG_ULX 8'h10
`define SWPP_REG_ULY 8'h14
`define SWPP_REG_WIDTH 8'h18
`define SWPP_REG_LENGTH 8'h1C
`define SWPP_REG_IMG 8'h20
`define SWPP_REG_MISC 8'h24
// Status bit positions
`define SWPP_ST_DONE 0
`define SWPP_ST_ERR 1
`define SWPP_ST_BUSY 2
// Composition codes and decoded modes
`define SWPP_COMP_LINE 8'h00
`define SWPP_COMP_GREY 8'h02
`define SWPP_COMP_BICOL 8'h03
`define SWPP_COMP_FULL 8'h05
`define SWPP_MODE_LINE 3'h0
`define SWPP_MODE_GREY 3'h1
`define SWPP_MODE_BICOL 3'h2
`define SWPP_MODE_FULL 3'h3
`define SWPP_MODE_BAD 3'h7
// AXI responses
`define SWPP_RESP_OKAY 2'h0
`define SWPP_RESP_SLVERR 2'h2
`endif

// >>> swpp_parser.v
// Purpose: takes the window-setup parameter list byte by byte and decodes it
// Assumes: inputs synchronous to sys_clk; one list per frame, ended by end_of_list
// Notes: decoded fields and result are readable over AXI4-Lite
`timescale 1ns/100ps
`include "swpp_defs.vh"

// How it works
// - One header, at most one descriptor
// - Horizontal resolution bytes 2-3, 72..300
// - Zero horizontal resolution means 72 dpi
// - Vertical resolution bytes 4-5, 72..300
// - Zero vertical resolution means 72 dpi
// - Composition 00/02/03/05 decoded to modes
module swpp_parser (
  // Clock and reset
  input wire sys_clk,
  input wire reset_n,
  // Parameter byte stream from the command transport
  input wire byte_valid,
  input wire [7:0] byte_data,
  input wire end_of_list,
  output wire byte_ready,
  // Result to the command transport
  output reg list_done,
  output reg illegal_param,
  // AXI4-Lite write address
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // AXI4-Lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);

  // Reset synchroniser
  reg rst_meta_q;
  reg rst_sync_q;
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end
  wire rst_n = rst_sync_q;

  // Resolution check with default substitution
  function [16:0] res_fix;
    input [15:0] raw;
    begin
      if (raw == 16'h0000)
        res_fix = {1'b1, `SWPP_RES_DEF};
      else
        res_fix = {(raw >= `SWPP_RES_MIN) && (raw <= `SWPP_RES_MAX), raw};
    end
  endfunction

  localparam ST_IDLE = 2'h0;
  localparam ST_RECV = 2'h1;
  localparam ST_DRAIN = 2'h2;

  reg [1:0] state_q;
  reg err_q, enable_q, done_q;
  reg [15:0] len_q, xraw_q, yraw_q;
  reg [31:0] ulx_q, uly_q, width_q, length_q;
  reg [7:0] idx_q, bright_q, thresh_q, contr_q, comp_q, bpp_q, cmpr_q, vrt_q, vrb_q;
  reg [1:0] pad_q;
  reg [2:0] mode_d;

  // Byte position within the descriptor
  wire [7:0] didx = idx_q - `SWPP_HDR_LEN;
  wire take = byte_valid && byte_ready;
  wire [16:0] xres = res_fix(xraw_q);
  wire [16:0] yres = res_fix(yraw_q);

  assign byte_ready = enable_q && (state_q != ST_IDLE);

  // Composition decode
  always @* begin
    case (comp_q)
      `SWPP_COMP_LINE: mode_d = `SWPP_MODE_LINE;
      `SWPP_COMP_GREY: mode_d = `SWPP_MODE_GREY;
      `SWPP_COMP_BICOL: mode_d = `SWPP_MODE_BICOL;
      `SWPP_COMP_FULL: mode_d = `SWPP_MODE_FULL;
      default: mode_d = `SWPP_MODE_BAD;
    endcase
  end

  // Reserved byte test: true where a nonzero byte is illegal
  function rsv_pos;
    input [7:0] i;
    begin
      rsv_pos = (i < 8'h06) || (i == 8'h09) || (i == 8'h23) || (i == 8'h24) ||
        (i == 8'h26) || (i == 8'h27) || ((i >= 8'h2A) && (i <= 8'h2F));
    end
  endfunction

  // Parser: counts bytes, captures fields, flags errors
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      idx_q <= 8'h00;
      err_q <= 1'b0;
      len_q <= 16'h0000;
      xraw_q <= 16'h0000;
      yraw_q <= 16'h0000;
      ulx_q <= 32'h0000_0000;
      uly_q <= 32'h0000_0000;
      width_q <= 32'h0000_0000;
      length_q <= 32'h0000_0000;
      bright_q <= 8'h00;
      thresh_q <= 8'h00;
      contr_q <= 8'h00;
      comp_q <= 8'h00;
      bpp_q <= 8'h00;
      pad_q <= 2'h0;
      cmpr_q <= 8'h00;
      vrt_q <= 8'h00;
      vrb_q <= 8'h00;
      list_done <= 1'b0;
      illegal_param <= 1'b0;
    end else begin
      list_done <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (enable_q) begin
            state_q <= ST_RECV;
            idx_q <= 8'h00;
            err_q <= 1'b0;
          end
        end
        ST_RECV: begin
          if (take) begin
            idx_q <= idx_q + 8'h01;
            if (rsv_pos(idx_q) && (byte_data != 8'h00))
              err_q <= 1'b1;
            if (idx_q == 8'h06)
              len_q[15:8] <= byte_data;
            if (idx_q == 8'h07)
              len_q[7:0] <= byte_data;
            if ((idx_q == `SWPP_HDR_LEN) && (byte_data != 8'h00))
              err_q <= 1'b1;
            if ((idx_q == 8'h25) && (byte_data[7:2] != 6'h00))
              err_q <= 1'b1;
            if (idx_q >= `SWPP_HDR_LEN) begin
              case (didx)
                8'h02: xraw_q[15:8] <= byte_data;
                8'h03: xraw_q[7:0] <= byte_data;
                8'h04: yraw_q[15:8] <= byte_data;
                8'h05: yraw_q[7:0] <= byte_data;
                8'h06, 8'h07, 8'h08, 8'h09: ulx_q <= {ulx_q[23:0], byte_data};
                8'h0A, 8'h0B, 8'h0C, 8'h0D: uly_q <= {uly_q[23:0], byte_data};
                8'h0E, 8'h0F, 8'h10, 8'h11: width_q <= {width_q[23:0], byte_data};
                8'h12, 8'h13, 8'h14, 8'h15: length_q <= {length_q[23:0], byte_data};
                8'h16: bright_q <= byte_data;
                8'h17: thresh_q <= byte_data;
                8'h18: contr_q <= byte_data;
                8'h19: comp_q <= byte_data;
                8'h1A: bpp_q <= byte_data;
                8'h1D: pad_q <= byte_data[1:0];
                8'h20: cmpr_q <= byte_data;
                8'h28: vrt_q <= byte_data;
                8'h29: vrb_q <= byte_data;
                default: ;
              endcase
            end
            if (idx_q == (`SWPP_TOTAL - 8'h01))
              state_q <= ST_DRAIN;
          end
          if (end_of_list)
            state_q <= ST_DRAIN;
        end
        ST_DRAIN: begin
          // Extra bytes straight after one descriptor, with no idle cycle between, make the list illegal
          if (take)
            err_q <= 1'b1;
          if (end_of_list || !take) begin
            state_q <= ST_IDLE;
            list_done <= 1'b1;
            illegal_param <= err_q || take || (len_q != `SWPP_DESC_LEN) ||
              ((idx_q != `SWPP_TOTAL) && (idx_q != `SWPP_HDR_LEN)) ||
              ((idx_q == `SWPP_TOTAL) && (!xres[16] || !yres[16] ||
              (mode_d == `SWPP_MODE_BAD)));
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Sticky done flag; a new completion wins over a clear
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      done_q <= 1'b0;
    else if (list_done)
      done_q <= 1'b1;
    else if (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid &&
             (s_axi_awaddr == `SWPP_REG_STATUS) && s_axi_wdata[`SWPP_ST_DONE])
      done_q <= 1'b0;
  end

  // Write channel: both address and data taken together
  wire wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SWPP_RESP_OKAY;
      enable_q <= 1'b0;
    end else begin
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `SWPP_RESP_OKAY;
        if (s_axi_awaddr == `SWPP_REG_CTRL) begin
          if (s_axi_wstrb[0])
            enable_q <= s_axi_wdata[0];
        end else if (s_axi_awaddr != `SWPP_REG_STATUS)
          s_axi_bresp <= `SWPP_RESP_SLVERR;
      end
    end
  end

  // Read channel: one outstanding read, answered next cycle
  assign s_axi_arready = !s_axi_rvalid;

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `SWPP_RESP_OKAY;
    end else begin
      if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
      if (s_axi_arvalid && !s_axi_rvalid) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `SWPP_RESP_OKAY;
        case (s_axi_araddr)
          `SWPP_REG_CTRL: s_axi_rdata <= {31'h0, enable_q};
          `SWPP_REG_STATUS: s_axi_rdata <= {29'h0, state_q != ST_IDLE,
                                            illegal_param, done_q};
          `SWPP_REG_XRES: s_axi_rdata <= {16'h0, xres[15:0]};
          `SWPP_REG_YRES: s_axi_rdata <= {16'h0, yres[15:0]};
          `SWPP_REG_ULX: s_axi_rdata <= ulx_q;
          `SWPP_REG_ULY: s_axi_rdata <= uly_q;
          `SWPP_REG_WIDTH: s_axi_rdata <= width_q;
          `SWPP_REG_LENGTH: s_axi_rdata <= length_q;
          `SWPP_REG_IMG: s_axi_rdata <= {bpp_q, 5'h0, mode_d, contr_q, bright_q};
          `SWPP_REG_MISC: s_axi_rdata <= {vrb_q, vrt_q, cmpr_q, thresh_q[5:0], pad_q};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `SWPP_RESP_SLVERR;
          end
        endcase
      end
    end
  end

endmodule

// >>> swpp_parser_properties.sv
// Purpose: port checks for the window-setup parser
// Assumes: one clock; reset_n low clears everything
// Notes: bound to every parser instance
`timescale 1ns/100ps
module swpp_parser_checker (
  // Clock and reset
  input wire sys_clk,
  input wire reset_n,
  // Stream side
  input wire byte_ready,
  input wire list_done,
  input wire illegal_param,
  // Register bus
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // List results
  a_done_pulse: assert property (list_done |=> !list_done)
    else $error("list done too long");
  a_done_cause: assert property ($rose(list_done) |-> $past(byte_ready))
    else $error("list done without stream");
  a_verdict_held: assert property ($changed(illegal_param) |-> list_done)
    else $error("verdict moved between lists");
  // Bus answers, the only way decoded fields leave the block
  a_wr_answer: assert property (s_axi_awvalid && s_axi_awready |=> s_axi_bvalid)
    else $error("no write response");
  a_wr_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready ##1 1'b1 |-> s_axi_rvalid)
    else $error("no read data");
  a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rvalid))
    else $error("read data dropped");
  a_rd_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  c_legal: cover property (list_done && !illegal_param);
  c_bad: cover property (list_done && illegal_param);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule
bind swpp_parser swpp_parser_checker i_chk (
  .sys_clk(sys_clk), .reset_n(reset_n), .byte_ready(byte_ready), .list_done(list_done),
  .illegal_param(illegal_param), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
);

// >>> swpp_host_model.sv
// Purpose: host side that sends window-setup parameter lists
// Assumes: bench calls build, may patch lst, then calls send
// Notes: an idle data line shows the inverse of its last byte
`timescale 1ns/100ps
module swpp_host_model (
  // Clock and stream
  input wire sys_clk,
  input wire byte_ready,
  output logic byte_valid,
  output logic [7:0] byte_data,
  output logic end_of_list
);
  logic [7:0] lst [0:63];
  initial begin
    byte_valid = 1'b0;
    byte_data = 8'h00;
    end_of_list = 1'b0;
  end
  // Bytes 14-34 except 33 (composition) carry their own index so field order shows
  task automatic build(input logic [15:0] xr, input logic [15:0] yr, input logic [7:0] comp);
    for (int k = 0; k < 64; k++) begin
      lst[k] = (k >= 14 && k <= 34) ? k[7:0] : 8'h00;
    end
    lst[7] = 8'h2A;
    lst[10] = xr[15:8];
    lst[11] = xr[7:0];
    lst[12] = yr[15:8];
    lst[13] = yr[7:0];
    lst[33] = comp;
    lst[37] = 8'h03;
    lst[48] = 8'hA5;
    lst[49] = 8'h5A;
  endtask
  // Gap gives a slow host; end_of_list closes the list
  task automatic send(input int n, input int gap);
    for (int k = 0; k < n; k++) begin
      repeat (gap) @(posedge sys_clk);
      byte_valid <= 1'b1;
      byte_data <= lst[k];
      do @(posedge sys_clk); while (!byte_ready);
      if (gap > 0 || k == n - 1) begin
        byte_valid <= 1'b0;
        byte_data <= ~lst[k];
      end
    end
    end_of_list <= 1'b1;
    @(posedge sys_clk);
    end_of_list <= 1'b0;
  endtask
endmodule

// >>> tb_top.sv
// Purpose: self-checking bench for the window-setup parser
// Assumes: host model drives the stream, bench drives the register bus
// Notes: expectations follow the list layout built by the host model
`timescale 1ns/100ps
`include "swpp_defs.vh"
module tb_top;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  wire byte_valid, end_of_list, byte_ready, list_done, illegal_param;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [7:0] byte_data;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  int bad_count = 0, compares = 0, cycles = 0;
  swpp_parser i_dut (.sys_clk(sys_clk), .reset_n(reset_n), .byte_valid(byte_valid),
    .byte_data(byte_data), .end_of_list(end_of_list), .byte_ready(byte_ready),
    .list_done(list_done), .illegal_param(illegal_param), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
  swpp_host_model i_host (.sys_clk(sys_clk), .byte_ready(byte_ready),
    .byte_valid(byte_valid), .byte_data(byte_data), .end_of_list(end_of_list));
  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [33:0] g, input logic [33:0] e);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Bus tasks; bready and rready stay high, so an answer is taken when seen
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do @(posedge sys_clk); while (!(s_axi_awready && s_axi_wready));
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    do @(posedge sys_clk); while (!s_axi_bvalid);
    chk({32'h0, s_axi_bresp}, {32'h0, (a == `SWPP_REG_CTRL || a == `SWPP_REG_STATUS) ?
      `SWPP_RESP_OKAY : `SWPP_RESP_SLVERR});
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge sys_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge sys_clk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    chk({32'h0, s_axi_rresp}, {32'h0, er});
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d, `SWPP_RESP_OKAY);
    chk({2'h0, d}, {2'h0, e});
  endtask
  // Sends one list, waits a bounded time for done, checks verdict and status
  task automatic run_list(input int n, input int gap, input logic ill);
    int k;
    logic [31:0] d;
    k = 0;
    fork
      i_host.send(n, gap);
      while (!list_done && k < 400) begin
        @(posedge sys_clk);
        k++;
      end
    join
    chk({32'h0, k < 400, illegal_param}, {32'h0, 1'b1, ill});
    rd(`SWPP_REG_STATUS, d, `SWPP_RESP_OKAY);
    chk({32'h0, d[1:0]}, {32'h0, ill, 1'b1});
    wr(`SWPP_REG_STATUS, 32'h1);
  endtask
  task automatic t_regs();
    logic [31:0] d;
    rchk(`SWPP_REG_CTRL, 32'h0);
    rd(8'h28, d, `SWPP_RESP_SLVERR);
    chk({2'h0, d}, 34'h0);
    wr(8'h28, 32'h1);
    wr(`SWPP_REG_CTRL, 32'h1);
    rchk(`SWPP_REG_CTRL, 32'h1);
    $display("test regs done");
  endtask
  task automatic t_legal();
    i_host.build(16'h012C, 16'h0048, `SWPP_COMP_FULL);
    run_list(50, 0, 1'b0);
    rchk(`SWPP_REG_XRES, 32'h12C);
    rchk(`SWPP_REG_YRES, 32'h48);
    rchk(`SWPP_REG_ULX, 32'h0E0F1011);
    rchk(`SWPP_REG_ULY, 32'h12131415);
    rchk(`SWPP_REG_WIDTH, 32'h16171819);
    rchk(`SWPP_REG_LENGTH, 32'h1A1B1C1D);
    rchk(`SWPP_REG_IMG, {8'h22, 5'h0, `SWPP_MODE_FULL, 16'h201E});
    rchk(`SWPP_REG_MISC, 32'h5AA5007F);
    rchk(`SWPP_REG_STATUS, 32'h4);
    $display("test legal done");
  endtask
  // Zero resolutions with a slow host, for each remaining composition
  task automatic t_modes();
    for (int m = 0; m < 3; m++) begin
      i_host.build(16'h0, 16'h0, (m == 0) ? 8'h00 : 8'(m + 1));
      run_list(50, 1, 1'b0);
      rchk(`SWPP_REG_XRES, 32'h48);
      rchk(`SWPP_REG_YRES, 32'h48);
      rchk(`SWPP_REG_IMG, {8'h22, 5'h0, 3'(m), 16'h201E});
    end
    $display("test modes done");
  endtask
  // Each row breaks one field: length, id, reserved bytes, padding, limits, composition
  task automatic t_illegal();
    int ix [8] = '{7, 8, 0, 42, 37, 38, 38, 33};
    logic [7:0] vv [8] = '{8'h2B, 8'h01, 8'h01, 8'h01, 8'h07, 8'h00, 8'h00, 8'h01};
    logic [15:0] xr [8] = '{72, 72, 72, 72, 72, 71, 72, 72};
    logic [15:0] yr [8] = '{72, 72, 72, 72, 72, 72, 301, 72};
    for (int k = 0; k < 8; k++) begin
      i_host.build(xr[k], yr[k], `SWPP_COMP_GREY);
      i_host.lst[ix[k]] = vv[k];
      run_list(50, k % 2, 1'b1);
    end
    $display("test illegal done");
  endtask
  task automatic t_frame();
    i_host.build(16'h0048, 16'h0048, `SWPP_COMP_LINE);
    run_list(8, 0, 1'b0);
    run_list(51, 0, 1'b1);
    run_list(20, 0, 1'b1);
    $display("test frame done");
  endtask
  task automatic final_report();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Hang guard, well above the roughly 1200 cycles the tests take
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      final_report();
    end
  end
  initial begin
    repeat (4) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    t_regs();
    t_legal();
    t_modes();
    t_illegal();
    t_frame();
    final_report();
  end
endmodule
